// ---- hw/fcis_params.svh ----
// register offsets, field positions, reset values and timing figures of the flash interrupt status block
`ifndef FCIS_PARAMS_SVH
`define FCIS_PARAMS_SVH

// register byte offsets on the local register port
`define FCIS_OFF_TADDR 8'h00
`define FCIS_OFF_WDATA 8'h04
`define FCIS_OFF_CMD 8'h08
`define FCIS_OFF_RAW 8'h0C
`define FCIS_OFF_MASK 8'h10
`define FCIS_OFF_MISC 8'h14
`define FCIS_OFF_RPROT 8'h30
`define FCIS_OFF_PPROT 8'h34

// status, mask and clear bit positions
`define FCIS_BIT_ACC 0
`define FCIS_BIT_PROG 1

// command register fields
`define FCIS_CMD_WRITE 3'h1
`define FCIS_CMD_ERASE 3'h2
`define FCIS_CMD_MERASE 3'h4
`define FCIS_KEY_LSB 16
`define FCIS_WRKEY 16'hA442

// reset values
`define FCIS_RST_ZERO 32'h0000_0000
`define FCIS_RST_PROT 32'hFFFF_FFFF

// protection granule: one enable bit per block of 2 KiB
`define FCIS_BLK_LSB 11
`define FCIS_BLK_W 5

// timing: figures in ns and the clock period
`define FCIS_CLK_PERIOD_NS 10
`define FCIS_WRITE_TIME_NS 50000
`define FCIS_ERASE_TIME_NS 25000000

`endif

// ---- hw/fcis_pkg.sv ----
// types shared by the flash interrupt status block and its program sequencer
package fcis_pkg;

    // one flag per event source
    typedef struct packed {
        logic prog;
        logic acc;
    } fcis_evt_t;

    // programming operation kinds
    typedef enum logic [1:0] {
        FCIS_OP_NONE,
        FCIS_OP_WRITE,
        FCIS_OP_ERASE,
        FCIS_OP_MERASE
    } fcis_op_t;

    // sequencer states
    typedef enum logic {
        FCIS_SEQ_IDLE,
        FCIS_SEQ_RUN
    } fcis_seq_t;

endpackage

// ---- hw/fcis_prog_seq.sv ----
// program/erase cycle timer: runs one operation and pulses done at its end
`timescale 1ns/10ps
`default_nettype none
`include "fcis_params.svh"
module fcis_prog_seq #(
    parameter int unsigned WRITE_CYCLES = 5000,
    parameter int unsigned ERASE_CYCLES = 2500000
) (
    input wire logic clk, // system clock
    input wire logic resetn, // async reset, low
    input wire logic start, // one-cycle start
    input wire fcis_pkg::fcis_op_t op, // kind of operation
    output logic busy_q, // operation running
    output logic done_q, // one-cycle completion
    output fcis_pkg::fcis_op_t op_q // operation in flight
);
    import fcis_pkg::*;

    fcis_seq_t state_q;
    logic [31:0] cnt_q;
    wire [31:0] load_val = (op == FCIS_OP_WRITE) ? WRITE_CYCLES - 32'd1 : ERASE_CYCLES - 32'd1;
    wire cnt_end = (cnt_q == 32'h0000_0000);

    // state, counter and completion pulse
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            state_q <= FCIS_SEQ_IDLE;
            cnt_q <= 32'h0000_0000;
            busy_q <= 1'b0;
            done_q <= 1'b0;
            op_q <= FCIS_OP_NONE;
        end else begin
            done_q <= 1'b0;
            case (state_q)
                FCIS_SEQ_IDLE: begin
                    if (start) begin
                        state_q <= FCIS_SEQ_RUN;
                        cnt_q <= load_val;
                        busy_q <= 1'b1;
                        op_q <= op;
                    end
                end
                FCIS_SEQ_RUN: begin
                    if (cnt_end) begin
                        state_q <= FCIS_SEQ_IDLE;
                        busy_q <= 1'b0;
                        done_q <= 1'b1;
                        op_q <= FCIS_OP_NONE;
                    end else begin
                        cnt_q <= cnt_q - 32'd1;
                    end
                end
                default: state_q <= FCIS_SEQ_IDLE;
            endcase
        end
    end
endmodule
`default_nettype wire

// ---- hw/fcis_top.sv ----
// flash controller interrupt status, mask and clear with command, protection and read-back
`timescale 1ns/10ps
`default_nettype none
`include "fcis_params.svh"
module fcis_top #(
    parameter int unsigned WRITE_CYCLES = `FCIS_WRITE_TIME_NS / `FCIS_CLK_PERIOD_NS,
    parameter int unsigned ERASE_CYCLES = `FCIS_ERASE_TIME_NS / `FCIS_CLK_PERIOD_NS
) (
    input wire logic clk, // system clock
    input wire logic resetn, // async reset, low
    input wire logic [7:0] addr, // register byte address
    input wire logic [31:0] wdata, // register write data
    input wire logic wr, // write strobe
    input wire logic rd, // read strobe
    input wire logic flash_read_req, // flash read by the fabric
    input wire logic [31:0] flash_read_addr, // address of that read
    output logic [31:0] rdata_q, // read data, cycle after rd
    output logic flash_irq_q, // flash interrupt level
    output logic flash_read_denied_q, // read refused by policy
    output logic prog_busy_q, // program cycle running
    output fcis_pkg::fcis_evt_t masked_q // masked status copy
);
    import fcis_pkg::*;

    // register state
    logic [31:0] taddr_q;
    logic [31:0] wdat_q;
    logic [31:0] rprot_q;
    logic [31:0] pprot_q;
    fcis_evt_t raw_q;
    fcis_evt_t raw_d;
    fcis_evt_t mask_q;
    fcis_evt_t mask_d;
    fcis_evt_t masked;
    fcis_evt_t misc_clr;
    logic [31:0] rdata_d;

    // sequencer handshake
    logic seq_busy;
    logic seq_done;
    fcis_op_t seq_op;
    fcis_op_t cmd_op;

    // address decode
    wire sel_taddr = (addr == `FCIS_OFF_TADDR);
    wire sel_wdat = (addr == `FCIS_OFF_WDATA);
    wire sel_cmd = (addr == `FCIS_OFF_CMD);
    wire sel_raw = (addr == `FCIS_OFF_RAW);
    wire sel_mask = (addr == `FCIS_OFF_MASK);
    wire sel_misc = (addr == `FCIS_OFF_MISC);
    wire sel_rprot = (addr == `FCIS_OFF_RPROT);
    wire sel_pprot = (addr == `FCIS_OFF_PPROT);

    // command decode: key must match and exactly one operation bit
    wire [2:0] cmd_bits = wdata[2:0];
    wire key_ok = (wdata[`FCIS_KEY_LSB +: 16] == `FCIS_WRKEY);
    wire is_write = (cmd_bits == `FCIS_CMD_WRITE);
    wire is_erase = (cmd_bits == `FCIS_CMD_ERASE);
    wire is_merase = (cmd_bits == `FCIS_CMD_MERASE);
    wire cmd_one = is_write | is_erase | is_merase;
    wire cmd_go = wr & sel_cmd & key_ok & cmd_one & ~seq_busy;
    assign cmd_op = is_write ? FCIS_OP_WRITE : (is_erase ? FCIS_OP_ERASE : FCIS_OP_MERASE);

    // protection policy: program needs the target block enabled, mass erase needs all
    wire [`FCIS_BLK_W-1:0] tgt_blk = taddr_q[`FCIS_BLK_LSB +: `FCIS_BLK_W];
    wire [`FCIS_BLK_W-1:0] rd_blk = flash_read_addr[`FCIS_BLK_LSB +: `FCIS_BLK_W];
    wire prog_allowed = is_merase ? (&pprot_q) : pprot_q[tgt_blk];
    wire seq_start = cmd_go & prog_allowed;
    wire prog_violation = cmd_go & ~prog_allowed;
    wire read_violation = flash_read_req & ~rprot_q[rd_blk];

    // event sources
    wire set_prog = seq_done;
    wire set_acc = prog_violation | read_violation;

    // write-one clears; zeros leave bits alone
    wire misc_wr = wr & sel_misc;
    assign misc_clr.prog = misc_wr & wdata[`FCIS_BIT_PROG];
    assign misc_clr.acc = misc_wr & wdata[`FCIS_BIT_ACC];

    // raw next state: a set in the same cycle beats the clear
    assign raw_d.prog = set_prog | (raw_q.prog & ~misc_clr.prog);
    assign raw_d.acc = set_acc | (raw_q.acc & ~misc_clr.acc);

    // mask next state
    wire mask_wr = wr & sel_mask;
    assign mask_d.prog = mask_wr ? wdata[`FCIS_BIT_PROG] : mask_q.prog;
    assign mask_d.acc = mask_wr ? wdata[`FCIS_BIT_ACC] : mask_q.acc;

    // masked status is raw AND mask
    assign masked.prog = raw_q.prog & mask_q.prog;
    assign masked.acc = raw_q.acc & mask_q.acc;

    // read multiplexer; reserved and unmapped bits read zero
    assign rdata_d = sel_taddr ? taddr_q :
        sel_wdat ? wdat_q :
        sel_cmd ? {29'h0000_0000, seq_op == FCIS_OP_MERASE, seq_op == FCIS_OP_ERASE, seq_op == FCIS_OP_WRITE} :
        sel_raw ? {30'h0000_0000, raw_q.prog, raw_q.acc} :
        sel_mask ? {30'h0000_0000, mask_q.prog, mask_q.acc} :
        sel_misc ? {30'h0000_0000, masked.prog, masked.acc} :
        sel_rprot ? rprot_q :
        sel_pprot ? pprot_q :
        `FCIS_RST_ZERO;

    // program/erase timer
    fcis_prog_seq #(
        .WRITE_CYCLES(WRITE_CYCLES),
        .ERASE_CYCLES(ERASE_CYCLES)
    ) u_seq (
        .clk(clk),
        .resetn(resetn),
        .start(seq_start),
        .op(cmd_op),
        .busy_q(seq_busy),
        .done_q(seq_done),
        .op_q(seq_op)
    );

    // software-owned configuration registers
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            taddr_q <= `FCIS_RST_ZERO;
            wdat_q <= `FCIS_RST_ZERO;
            rprot_q <= `FCIS_RST_PROT;
            pprot_q <= `FCIS_RST_PROT;
        end else if (wr) begin
            if (sel_taddr) taddr_q <= wdata;
            if (sel_wdat) wdat_q <= wdata;
            if (sel_rprot) rprot_q <= rprot_q & wdata;
            if (sel_pprot) pprot_q <= pprot_q & wdata;
        end
    end

    // status, mask and interrupt level
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            raw_q <= '0;
            mask_q <= '0;
            masked_q <= '0;
            flash_irq_q <= 1'b0;
        end else begin
            raw_q <= raw_d;
            mask_q <= mask_d;
            masked_q <= raw_d & mask_d;
            flash_irq_q <= |(raw_d & mask_d);
        end
    end

    // read data, busy and read-denied outputs
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            rdata_q <= `FCIS_RST_ZERO;
            flash_read_denied_q <= 1'b0;
            prog_busy_q <= 1'b0;
        end else begin
            rdata_q <= rd ? rdata_d : `FCIS_RST_ZERO;
            flash_read_denied_q <= read_violation;
            prog_busy_q <= seq_busy | seq_start;
        end
    end

    // checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);

    chk_done_sets_raw: assert property (
        seq_done |=> raw_q.prog
    ) else $error("program completion did not set raw bit");

    chk_keyed_start_only: assert property (
        seq_start |-> (wr && sel_cmd && key_ok && !seq_busy)
    ) else $error("program cycle started without keyed command write");

    chk_erase_starts: assert property (
        (seq_start && (is_erase || is_merase)) |=> seq_busy && (seq_op == FCIS_OP_ERASE || seq_op == FCIS_OP_MERASE)
    ) else $error("erase did not start as a program cycle");

    chk_violation_flags: assert property (
        (flash_read_req && !rprot_q[rd_blk]) |=> raw_q.acc
    ) else $error("read violation not recorded");

    chk_irq_follows_mask: assert property (
        flash_irq_q == ((raw_q.prog && mask_q.prog) || (raw_q.acc && mask_q.acc))
    ) else $error("interrupt does not match masked status");

    chk_masked_prog_read: assert property (
        (rd && sel_misc) |=> rdata_q[`FCIS_BIT_PROG] == $past(raw_q.prog & mask_q.prog)
    ) else $error("masked program bit read wrong");

    chk_masked_acc_read: assert property (
        (rd && sel_misc) |=> rdata_q[`FCIS_BIT_ACC] == $past(raw_q.acc & mask_q.acc)
    ) else $error("masked access bit read wrong");

    chk_prog_clear: assert property (
        (misc_wr && wdata[`FCIS_BIT_PROG] && !seq_done) |=> !raw_q.prog && !masked_q.prog
    ) else $error("write one did not clear program bits");

    chk_acc_clear: assert property (
        (misc_wr && wdata[`FCIS_BIT_ACC] && !set_acc) |=> !raw_q.acc && !masked_q.acc
    ) else $error("write one did not clear access bits");

    chk_zero_write_keeps: assert property (
        (wr && (sel_raw || (sel_misc && wdata[1:0] == 2'h0))) |=> raw_q == $past(raw_q) || $past(set_prog || set_acc)
    ) else $error("raw bits changed on ignored write");

    chk_reserved_zero: assert property (
        $past(rd && (sel_raw || sel_mask || sel_misc)) |-> rdata_q[31:2] == 30'h0000_0000
    ) else $error("reserved status bits not zero");

    chk_masked_suppress: assert property (
        (!mask_q.prog && !mask_q.acc && !mask_wr) |=> !flash_irq_q
    ) else $error("interrupt forwarded while masked");

    chk_acc_forward: assert property (
        (mask_q.acc && raw_q.acc) |-> flash_irq_q
    ) else $error("access event not forwarded");

    chk_irq_level_hold: assert property (
        (flash_irq_q && !misc_wr && !mask_wr) |=> flash_irq_q
    ) else $error("interrupt level dropped without clear");

    chk_reset_clear: assert property (
        $rose(resetn) |-> (raw_q == '0 && mask_q == '0 && !flash_irq_q)
    ) else $error("status not zero after reset");

    // a mask write lands in the next cycle
    chk_mask_write_lands: assert property (
        mask_wr |=> mask_q == $past(wdata[`FCIS_BIT_PROG:`FCIS_BIT_ACC])
    ) else $error("mask write did not land");

    // mask holds without a write
    chk_mask_holds: assert property (
        !mask_wr |=> mask_q == $past(mask_q)
    ) else $error("mask changed without a write");

    // raw program bit moves only on completion or clear
    chk_raw_prog_holds: assert property (
        (!seq_done && !misc_clr.prog) |=> raw_q.prog == $past(raw_q.prog)
    ) else $error("raw program bit changed without cause");

    // raw access bit moves only on a violation or clear
    chk_raw_acc_holds: assert property (
        (!set_acc && !misc_clr.acc) |=> raw_q.acc == $past(raw_q.acc)
    ) else $error("raw access bit changed without cause");

    // a refused program command records an access event
    chk_prog_viol_flags: assert property (
        prog_violation |=> raw_q.acc
    ) else $error("program violation not recorded");

    // read-denied output follows a refused read by one cycle
    chk_denied_follows: assert property (
        flash_read_denied_q == $past(read_violation)
    ) else $error("read denied output wrong");

    // masked copy equals raw AND mask
    chk_masked_copy: assert property (
        masked_q == (raw_q & mask_q)
    ) else $error("masked copy differs from raw and mask");

    // no start while a cycle runs
    chk_no_start_busy: assert property (
        seq_busy |-> !seq_start
    ) else $error("program cycle started while busy");

    // an accepted command shows busy next cycle
    chk_start_busy: assert property (
        seq_start |=> prog_busy_q && seq_busy
    ) else $error("accepted command not busy");

    // completion pulse comes only after the run
    chk_done_not_busy: assert property (
        seq_done |-> !seq_busy
    ) else $error("completion while still busy");

    // idle read data stand at zero
    chk_rdata_idle_zero: assert property (
        !rd |=> rdata_q == `FCIS_RST_ZERO
    ) else $error("read data not zero outside a read");

    // raw status read-back
    chk_raw_read: assert property (
        (rd && sel_raw) |=> rdata_q[`FCIS_BIT_PROG:`FCIS_BIT_ACC] == $past(raw_q)
    ) else $error("raw status read wrong");

    // mask read-back
    chk_mask_read: assert property (
        (rd && sel_mask) |=> rdata_q[`FCIS_BIT_PROG:`FCIS_BIT_ACC] == $past(mask_q)
    ) else $error("mask read wrong");

    // enabled program event reaches the interrupt
    chk_prog_forward: assert property (
        (mask_q.prog && raw_q.prog) |-> flash_irq_q
    ) else $error("program event not forwarded");

    // access event alone is held back by its mask
    chk_acc_suppress: assert property (
        (!mask_q.acc && !(raw_q.prog && mask_q.prog)) |-> !flash_irq_q
    ) else $error("access event forwarded while masked");

    // clearing both bits drops the level
    chk_irq_drops: assert property (
        (flash_irq_q && misc_clr.prog && misc_clr.acc && !set_prog && !set_acc) |=> !flash_irq_q
    ) else $error("interrupt level held after full clear");

    // completion is a single pulse
    chk_done_pulse: assert property (
        seq_done |=> !seq_done
    ) else $error("completion pulse longer than a cycle");

    // no completion without a run
    chk_idle_no_done: assert property (
        !seq_busy |=> !seq_done
    ) else $error("completion without a running cycle");

    // busy output drops after completion
    chk_busy_drops: assert property (
        (seq_done && !seq_start) |=> !prog_busy_q
    ) else $error("busy held after completion");

    // a command without the key starts nothing
    chk_bad_key_ignored: assert property (
        (wr && sel_cmd && !key_ok && !seq_busy) |=> !seq_busy
    ) else $error("unkeyed command started a cycle");

    // idle command register reads zero
    chk_cmd_idle_read: assert property (
        (rd && sel_cmd && !seq_busy) |=> rdata_q == `FCIS_RST_ZERO
    ) else $error("idle command register not zero");

    // mass erase needs every block enabled
    chk_merase_needs_all: assert property (
        (cmd_go && is_merase && !(&pprot_q)) |-> !seq_start
    ) else $error("mass erase started with a protected block");

    // word write runs as a program cycle
    chk_write_starts: assert property (
        (seq_start && is_write) |=> seq_busy && seq_op == FCIS_OP_WRITE
    ) else $error("word write did not start as a program cycle");

endmodule
`default_nettype wire

// ---- tb/fcis_fabric_model.sv ----
// fabric side model: issues flash array reads into the block
`timescale 1ns/10ps
`default_nettype none
module fcis_fabric_model (
    output logic req, // read request
    output logic [31:0] addr, // read address
    input wire logic clk // system clock
);
    // idle state: no request pending
    initial begin
        req = 1'b0;
        addr = 32'h0000_0000;
    end
    // one access: a single request cycle, then the address goes stale-inverted
    task automatic do_read(input logic [31:0] a);
        @(posedge clk);
        req <= 1'b1;
        addr <= a;
        @(posedge clk);
        req <= 1'b0;
        addr <= ~a;
    endtask
endmodule
`default_nettype wire

// ---- tb/fcis_top_tb_top.sv ----
// self-checking bench of the flash interrupt status block
`timescale 1ns/10ps
`default_nettype none
`include "fcis_params.svh"
module fcis_top_tb_top;
    import fcis_pkg::*;
    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [31:0] wdata = 32'h0000_0000;
    logic wr = 1'b0;
    logic rd = 1'b0;
    wire logic fab_req;
    wire logic [31:0] fab_addr;
    wire logic [31:0] rdata_q;
    wire logic flash_irq_q;
    wire logic flash_read_denied_q;
    wire logic prog_busy_q;
    wire fcis_evt_t masked_q;
    int error_cnt = 0;
    int compares = 0;
    logic [2:0] ops [3] = '{3'h1, 3'h2, 3'h4};

    // 100 MHz clock
    always #5 clk = ~clk;

    // short counts keep program cycles quick
    fcis_top #(.WRITE_CYCLES(4), .ERASE_CYCLES(8)) dut (
        .clk(clk), .resetn(resetn), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
        .flash_read_req(fab_req), .flash_read_addr(fab_addr), .rdata_q(rdata_q),
        .flash_irq_q(flash_irq_q), .flash_read_denied_q(flash_read_denied_q),
        .prog_busy_q(prog_busy_q), .masked_q(masked_q)
    );
    fcis_fabric_model fab (.req(fab_req), .addr(fab_addr), .clk(clk));

    // verdict and end of run
    task automatic results();
        $display("compares %0d error_cnt %0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        compares++;
        if (got !== exp) begin
            error_cnt++;
            $display("ERROR at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask
    // register port write: one strobe cycle
    task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    // register port read: data stands in the following cycle only
    task automatic reg_rd(input logic [7:0] a, input logic [31:0] exp, input string what);
        @(posedge clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        chk(rdata_q, exp, what);
    endtask
    // interrupt level and masked copy as {irq, prog, acc}
    task automatic irq_is(input logic [2:0] e);
        #1;
        chk({29'h0, flash_irq_q, masked_q}, {29'h0, e}, "irq");
    endtask
    task automatic wait_idle();
        int i;
        for (i = 0; i < 200; i++) begin
            @(posedge clk);
            #1;
            if (prog_busy_q === 1'b0) break;
        end
        if (i == 200) begin
            error_cnt++;
            $display("ERROR at %0t: program cycle never ended", $time);
            results();
        end
    endtask

    // main sequence
    initial begin
        repeat (8) @(posedge clk);
        resetn <= 1'b1;
        reg_rd(`FCIS_OFF_RAW, 32'h0, "raw reset");
        reg_rd(`FCIS_OFF_MASK, 32'h0, "mask reset");
        reg_rd(`FCIS_OFF_MISC, 32'h0, "masked reset");
        reg_wr(`FCIS_OFF_RAW, 32'hFFFF_FFFF);
        reg_rd(`FCIS_OFF_RAW, 32'h0, "raw written");
        reg_wr(`FCIS_OFF_CMD, 32'h1234_0001);
        irq_is(3'b000);
        chk({31'h0, prog_busy_q}, 32'h0, "bad key start");
        $display("test reset and refusals done");
        // every command kind, first masked then unmasked
        foreach (ops[k]) begin
            reg_wr(`FCIS_OFF_MASK, 32'h0);
            reg_wr(`FCIS_OFF_CMD, {`FCIS_WRKEY, 13'h0, ops[k]});
            irq_is(3'b000);
            chk({31'h0, prog_busy_q}, 32'h1, "busy");
            reg_rd(`FCIS_OFF_CMD, {29'h0, ops[k]}, "op in flight");
            wait_idle();
            reg_rd(`FCIS_OFF_RAW, 32'h2, "raw prog");
            reg_rd(`FCIS_OFF_MISC, 32'h0, "masked off");
            irq_is(3'b000);
            reg_wr(`FCIS_OFF_MASK, 32'h2);
            irq_is(3'b110);
            reg_rd(`FCIS_OFF_MISC, 32'h2, "masked on");
            reg_wr(`FCIS_OFF_MISC, 32'h1);
            reg_rd(`FCIS_OFF_RAW, 32'h2, "zero clear");
            reg_wr(`FCIS_OFF_MISC, 32'h2);
            irq_is(3'b000);
            reg_rd(`FCIS_OFF_RAW, 32'h0, "raw cleared");
        end
        $display("test program events done");
        // read policy: block 0 read-disabled, block 1 allowed
        reg_wr(`FCIS_OFF_MASK, 32'h0);
        reg_wr(`FCIS_OFF_RPROT, 32'hFFFF_FFFE);
        fab.do_read(32'h0000_0800);
        #1;
        chk({31'h0, flash_read_denied_q}, 32'h0, "allowed read");
        reg_rd(`FCIS_OFF_RAW, 32'h0, "raw no acc");
        fab.do_read(32'h0000_0010);
        #1;
        chk({31'h0, flash_read_denied_q}, 32'h1, "denied read");
        reg_rd(`FCIS_OFF_RAW, 32'h1, "raw acc");
        reg_rd(`FCIS_OFF_MISC, 32'h0, "acc masked off");
        reg_wr(`FCIS_OFF_MASK, 32'h1);
        irq_is(3'b101);
        reg_wr(`FCIS_OFF_MISC, 32'h1);
        irq_is(3'b000);
        reg_rd(`FCIS_OFF_RAW, 32'h0, "acc cleared");
        // program policy: write into a program-disabled block
        reg_wr(`FCIS_OFF_PPROT, 32'hFFFF_FFFD);
        reg_wr(`FCIS_OFF_TADDR, 32'h0000_0800);
        reg_wr(`FCIS_OFF_CMD, 32'hA442_0001);
        irq_is(3'b101);
        chk({31'h0, prog_busy_q}, 32'h0, "protected start");
        // both events: level holds until both are cleared
        reg_wr(`FCIS_OFF_MASK, 32'h3);
        reg_wr(`FCIS_OFF_TADDR, 32'h0000_0000);
        reg_wr(`FCIS_OFF_CMD, 32'hA442_0002);
        wait_idle();
        irq_is(3'b111);
        reg_wr(`FCIS_OFF_MISC, 32'h1);
        irq_is(3'b110);
        reg_wr(`FCIS_OFF_MISC, 32'h2);
        irq_is(3'b000);
        reg_rd(`FCIS_OFF_RAW, 32'h0, "all cleared");
        $display("test access events done");
        // reset in mid-run drops pending and enabled state
        reg_wr(`FCIS_OFF_MASK, 32'h3);
        fab.do_read(32'h0000_0010);
        irq_is(3'b101);
        @(posedge clk);
        resetn <= 1'b0;
        irq_is(3'b000);
        repeat (2) @(posedge clk);
        resetn <= 1'b1;
        reg_rd(`FCIS_OFF_RAW, 32'h0, "raw mid reset");
        reg_rd(`FCIS_OFF_MASK, 32'h0, "mask mid reset");
        reg_rd(`FCIS_OFF_MISC, 32'h0, "masked mid reset");
        $display("test mid-run reset done");
        results();
    end
endmodule
`default_nettype wire
